// ### acsr_cfg.svh
/*
  Constants of the accumulating converter readout: timing, widths, limits.
  Assumes it is included by the package and the design files by bare name.
*/
`ifndef ACSR_CFG_SVH
`define ACSR_CFG_SVH

`define ACSR_CLK_MHZ      25
`define ACSR_CONV_TIME_NS 750
// Least time, so round up to whole cycles
`define ACSR_CONV_CYC     ((`ACSR_CONV_TIME_NS * `ACSR_CLK_MHZ + 999) / 1000)
`define ACSR_MAX_ACC      1024
`define ACSR_RES_FULL     14
`define ACSR_RES_SHORT    12
`define ACSR_WORD_MAX     24
`define ACSR_CNT_W        11
`define ACSR_NB_W         5
`define ACSR_TMR_W        5
`define ACSR_LOG_MAX      10

`endif

// ### acsr_pkg.sv
/*
  Types shared by the readout design.
  Assumes acsr_cfg.svh is on the include path.
*/
`include "acsr_cfg.svh"

package acsr_pkg;
  typedef enum logic [1:0] {
    ACSR_IDLE,
    ACSR_CONV,
    ACSR_HOLD
  } acsr_conv_t;

  typedef logic signed [`ACSR_WORD_MAX-1:0] acsr_word_t;
  typedef logic [`ACSR_NB_W-1:0]            acsr_nbits_t;
endpackage : acsr_pkg

// ### acsr_ser_if.sv
/*
  Carrier between the readout controller and its output serializer.
  Assumes both ends share one clock and reset.
*/
`timescale 1ns/1ps
`include "acsr_cfg.svh"

interface acsr_ser_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic                load;
  acsr_pkg::acsr_word_t word;
  acsr_pkg::acsr_nbits_t nbits;
  logic                busy_bit;
  logic                fall;
  logic                stop;
  logic                sdo;
  logic                oe;

  modport ctrl (input clk, rst_n, sdo, oe,
                output load, word, nbits, busy_bit, fall, stop);
  modport ser  (input clk, rst_n, load, word, nbits, busy_bit, fall, stop,
                output sdo, oe);
endinterface : acsr_ser_if

// ### acsr_shifter.sv
/*
  Output serializer: optional low busy bit, then the word MSB first,
  one bit per serial clock falling edge.
  Assumes fall is a one-cycle pulse on core clock and stop a level.
*/
`timescale 1ns/1ps
`include "acsr_cfg.svh"

module acsr_shifter (
  acsr_ser_if.ser s
);
  import acsr_pkg::*;

  logic [`ACSR_WORD_MAX:0]  sh_q;
  logic [`ACSR_NB_W:0]      rem_q;
  acsr_word_t               aligned;

  // Left-align so the word's own MSB leaves first
  assign aligned = s.word << (5'(`ACSR_WORD_MAX) - s.nbits);

  always_ff @(posedge s.clk or negedge s.rst_n) begin
    if (!s.rst_n) begin
      sh_q  <= '0;
      rem_q <= '0;
    end else if (s.stop) begin
      rem_q <= '0;
    end else if (s.load) begin
      // R19 busy bit low
      sh_q  <= s.busy_bit ? {1'b0, aligned} : {aligned, 1'b0};
      rem_q <= {1'b0, s.nbits} + {5'h00, s.busy_bit};
    end else if (s.fall && rem_q != '0) begin
      // R11 shift on falling
      sh_q  <= {sh_q[`ACSR_WORD_MAX-1:0], 1'b0};
      rem_q <= rem_q - 6'h01;
    end
  end

  assign s.sdo = sh_q[`ACSR_WORD_MAX];
  // Released after the last bit's falling edge
  assign s.oe  = (rem_q != '0);

  default clocking @(posedge s.clk); endclocking
  default disable iff (!s.rst_n);

  shift_on_fall_a: assert property ( // R11
    s.oe && $past(s.oe) && $changed(s.sdo) |-> $past(s.fall || s.load))
    else $error("data output moved without a falling edge");

  release_count_a: assert property ( // R5
    s.load && !s.stop && !s.busy_bit |=> rem_q == {1'b0, $past(s.nbits)})
    else $error("bit count does not match word width");
endmodule : acsr_shifter

// ### acsr_top.sv
/*
  Digital side of an accumulating SAR converter with three-wire readout.
  Assumes the analog core presents its code on sar_code at the end of the
  conversion time; the serial pins are asynchronous to core_clk.
*/
// How it works
// R1 - Sum consecutive unread conversions, never more than 1024 of them.
// R2 - Host sends no serial clock during conversions meant to be summed.
// R3 - Any serial clock pulse before next start drops the sum, restarts.
// R4 - A conversion without intervening clock adds to the stored sum.
// R5 - Host reads the sum with as many clocks as the word has bits.
// R6 - Word is 14 bits, plus one per doubling, 24 for 513 to 1024.
// R7 - The 12-bit variant sequences identically with two fewer bits.
// R8 - Pins: conversion start and select, mode select, data out, clock.
// R9 - The host starts every transfer; the device is only a slave.
// R10 - Host uses clock mode 0,0: idle low, rising before falling.
// R11 - Each data bit is shifted out on a serial clock falling edge.
// R12 - Mode select high at start: three-wire without busy bit.
// R13 - Mode select low at start: three-wire with busy bit.
// R14 - The busy bit comes before the data bits.
// R15 - Host lowers start after max time, or before it with busy.
// R16 - Words leave MSB first; the first bit is the sign.
// R17 - Results are two's complement; negative full scale is one then zeros.
// R18 - A start rising edge begins a conversion that always completes.
// R19 - With busy bit, data output drives low once conversion completes.
// R20 - Each result is sign-extended before it is added.
`timescale 1ns/1ps
`include "acsr_cfg.svh"

module acsr_top (
  input  wire logic                          core_clk,
  input  wire logic                          nrst,
  input  wire logic                          conversion_start_select,
  input  wire logic                          mode_select,
  input  wire logic                          sclk,
  input  wire logic [`ACSR_RES_FULL-1:0]     sar_code,
  input  wire logic                          short_res,
  output logic                               sdo,
  output logic                               sdo_oe,
  output logic                               conv_busy,
  output logic [`ACSR_CNT_W-1:0]             acc_count,
  output acsr_pkg::acsr_nbits_t              word_bits
);
  import acsr_pkg::*;

  localparam int CONV_CYC_I = `ACSR_CONV_CYC;

  acsr_conv_t                 state_q;
  logic [`ACSR_TMR_W-1:0]     tmr_q;
  logic [2:0]                 s1_q;
  logic [2:0]                 s2_q;
  logic [2:0]                 s3_q;
  logic                       cnv_s;
  logic                       cnv_rise;
  logic                       sclk_rise;
  logic                       sclk_fall;
  logic                       clk_seen_q;
  logic                       fresh_q;
  logic                       busy_mode_q;
  logic                       short_q;
  logic                       loaded_q;
  logic                       done;
  acsr_word_t                 acc_q;
  acsr_word_t                 sample_ext;
  logic [`ACSR_CNT_W-1:0]     cnt_q;
  logic [3:0]                 lg;
  acsr_nbits_t                nbits;

  acsr_ser_if ser (.clk(core_clk), .rst_n(nrst));

  acsr_shifter u_shift (.s(ser.ser));

  // R8 pins pass two flops before use; third stage finds edges
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {conversion_start_select, mode_select, sclk};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign cnv_s     = s2_q[2];
  assign cnv_rise  = s2_q[2] && !s3_q[2];
  // R10 idle-low clock, rising edges mark pulses
  assign sclk_rise = s2_q[0] && !s3_q[0];
  assign sclk_fall = !s2_q[0] && s3_q[0];
  assign done      = (state_q == ACSR_CONV) && (tmr_q == '0);

  // R18 start edge runs full conversion
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ACSR_IDLE;
      tmr_q   <= '0;
    end else begin
      unique case (state_q)
        ACSR_IDLE, ACSR_HOLD: begin
          if (cnv_rise) begin
            state_q <= ACSR_CONV;
            tmr_q   <= `ACSR_TMR_W'(CONV_CYC_I - 1);
          end
        end
        ACSR_CONV: begin
          // Start edges are ignored until the conversion ends
          if (tmr_q == '0) begin
            state_q <= ACSR_HOLD;
          end else begin
            tmr_q <= tmr_q - 5'h01;
          end
        end
      endcase
    end
  end

  // R12 R13 mode taken at start edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busy_mode_q <= 1'b0;
      short_q     <= 1'b0;
    end else if (cnv_rise && state_q != ACSR_CONV) begin
      busy_mode_q <= !s2_q[1];
      short_q     <= short_res;
    end
  end

  // R3 clock pulse marks sample read
  // Reset value starts the first conversion fresh; an edge in the
  // start cycle is still counted
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      clk_seen_q <= 1'b1;
      fresh_q    <= 1'b1;
    end else if (cnv_rise && state_q != ACSR_CONV) begin
      fresh_q    <= clk_seen_q || sclk_rise;
      clk_seen_q <= 1'b0;
    end else if (sclk_rise) begin
      clk_seen_q <= 1'b1;
    end
  end

  // R17 top code bit is the sign
  // R20 sign-extend before adding
  // R7 short variant uses 12 low bits
  assign sample_ext = short_q
    ? {{(`ACSR_WORD_MAX-`ACSR_RES_SHORT){sar_code[`ACSR_RES_SHORT-1]}},
       sar_code[`ACSR_RES_SHORT-1:0]}
    : {{(`ACSR_WORD_MAX-`ACSR_RES_FULL){sar_code[`ACSR_RES_FULL-1]}},
       sar_code};

  // R1 R4 accumulate unread conversions
  // A full count restarts rather than overflow the 24-bit word
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc_q <= '0;
      cnt_q <= '0;
    end else if (done) begin
      if (fresh_q || cnt_q == `ACSR_CNT_W'(`ACSR_MAX_ACC)) begin
        acc_q <= sample_ext;
        cnt_q <= `ACSR_CNT_W'(1);
      end else begin
        acc_q <= acc_q + sample_ext;
        cnt_q <= cnt_q + 11'h001;
      end
    end
  end

  // R6 width grows per doubling
  always_comb begin
    lg = '0;
    for (int i = 0; i < `ACSR_LOG_MAX; i++) begin
      if (cnt_q > (`ACSR_CNT_W'(1) << i)) begin
        lg = 4'(i + 1);
      end
    end
    nbits = (short_q ? `ACSR_NB_W'(`ACSR_RES_SHORT)
                     : `ACSR_NB_W'(`ACSR_RES_FULL)) + {1'b0, lg};
  end

  // Word loads once per conversion, in HOLD while the start pin is low
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      loaded_q <= 1'b0;
    end else if (cnv_rise) begin
      loaded_q <= 1'b0;
    end else if (ser.load) begin
      loaded_q <= 1'b1;
    end
  end

  // R14 R16 busy bit then MSB
  assign ser.load     = (state_q == ACSR_HOLD) && !cnv_s && !loaded_q;
  assign ser.word     = acc_q;
  assign ser.nbits    = nbits;
  assign ser.busy_bit = busy_mode_q;
  // R11 only falling edges while selected
  assign ser.fall     = sclk_fall && !cnv_s;
  assign ser.stop     = cnv_s;

  assign sdo       = ser.sdo;
  assign sdo_oe    = ser.oe;
  assign conv_busy = (state_q == ACSR_CONV);
  assign acc_count = cnt_q;
  assign word_bits = nbits;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  conv_length_a: assert property ( // R18
    $rose(state_q == ACSR_CONV) |-> ##CONV_CYC_I state_q == ACSR_HOLD)
    else $error("conversion did not last its fixed time");

  acc_restart_a: assert property ( // R3
    done && fresh_q |=> cnt_q == 11'h001 && acc_q == $past(sample_ext))
    else $error("read sample was not discarded");

  acc_add_a: assert property ( // R4
    done && !fresh_q && cnt_q < 11'h400
      |=> acc_q == $past(acc_q) + $past(sample_ext)
          && cnt_q == $past(cnt_q) + 11'h001)
    else $error("unread conversion not added to sum");

  acc_limit_a: assert property ( // R1
    cnt_q <= 11'h400)
    else $error("more than 1024 conversions summed");

  word_width_a: assert property ( // R6
    (!short_q && cnt_q == 11'h001 |-> nbits == 5'h0e)
    and (!short_q && cnt_q > 11'h200 |-> nbits == 5'h18))
    else $error("word width wrong for sample count");

  busy_first_a: assert property ( // R19
    ser.load && busy_mode_q |=> sdo_oe && !sdo)
    else $error("busy bit not driven low first");

  sign_first_a: assert property ( // R16
    ser.load && !busy_mode_q |=> sdo_oe && sdo == $past(acc_q[23]))
    else $error("first bit is not the sign");

  select_release_a: assert property ( // R12
    cnv_s |=> !sdo_oe)
    else $error("data output driven while start is high");
endmodule : acsr_top

// ### acsr_host.sv
/*
  Host model of the three-wire readout: start pin, mode select and a
  mode 0,0 serial clock of 320 ns, plus a data line with pull-up.
  Assumes the bench calls its tasks just after a core_clk rising edge.
*/
`timescale 1ns/1ps

module acsr_host (
  input  wire logic core_clk,
  input  wire logic sdo,
  input  wire logic sdo_oe,
  output logic      start_sel,
  output logic      mode_sel,
  output logic      sclk
);
  logic line;

  // Pull-up holds the line high while the device lets go
  assign line = sdo_oe ? sdo : 1'b1;

  // host drives start, mode select and clock; clock idles low
  initial begin
    start_sel = 1'b0;
    mode_sel  = 1'b1;
    sclk      = 1'b0;
  end

  task automatic conv(input logic busy);
    mode_sel  <= ~busy;
    start_sel <= 1'b1;
    repeat (busy ? 8 : 28) @(posedge core_clk);
    start_sel <= 1'b0;
    repeat (busy ? 26 : 6) @(posedge core_clk);
  endtask : conv

  // n clocks, sampled before each fall
  task automatic rd(input int n, output logic [24:0] w);
    w = '0;
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
      w = {w[23:0], line};
      sclk <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
  endtask : rd
endmodule : acsr_host

// ### acsr_top_tb_top.sv
/*
  Self-checking bench of the accumulating readout, with a host model.
  Assumes the design package, interface and modules are compiled first.
*/
`timescale 1ns/1ps

module acsr_top_tb_top;
  import acsr_pkg::*;
  logic        core_clk;
  logic        nrst;
  logic        start_sel;
  logic        mode_sel;
  logic        sclk;
  logic        short_res;
  logic        sdo;
  logic        sdo_oe;
  logic        conv_busy;
  logic [13:0] sar_code;
  logic [10:0] acc_count;
  acsr_nbits_t word_bits;
  logic [23:0] sum;
  logic [24:0] w;
  int          seed = 23;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          ks[8] = '{1, 1, 2, 3, 5, 9, 17, 1024};

  acsr_top acsr_top_inst (.core_clk(core_clk), .nrst(nrst),
    .conversion_start_select(start_sel), .mode_select(mode_sel),
    .sclk(sclk), .sar_code(sar_code), .short_res(short_res), .sdo(sdo),
    .sdo_oe(sdo_oe), .conv_busy(conv_busy), .acc_count(acc_count),
    .word_bits(word_bits));

  acsr_host acsr_host_inst (.core_clk(core_clk), .sdo(sdo),
    .sdo_oe(sdo_oe), .start_sel(start_sel), .mode_sel(mode_sel),
    .sclk(sclk));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic check(input logic [24:0] got, input logic [24:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  function automatic logic [23:0] ext(input logic [13:0] c, input logic s);
    return s ? {{12{c[11]}}, c[11:0]} : {{10{c[13]}}, c};
  endfunction : ext

  function automatic int nb(input int k, input logic s);
    return (s ? 12 : 14) + $clog2(k);
  endfunction : nb

  // Negative full scale when k is 1, random codes otherwise
  task automatic acc(input int k, input logic b, input logic s);
    logic [13:0] c;
    for (int i = 0; i < k; i++) begin
      c = (k == 1) ? (s ? 14'h0800 : 14'h2000) : 14'($random(seed));
      sar_code  <= c;
      short_res <= s;
      sum = (i == 0 ? 24'h0 : sum) + ext(c, s);
      fork
        acsr_host_inst.conv(b);
        begin
          // Mid-conversion busy, then idle well before the next start
          repeat (12) @(posedge core_clk);
          check(25'(conv_busy), 25'h1);
          repeat (14) @(posedge core_clk);
          check(25'(conv_busy), 25'h0);
        end
      join
    end
  endtask : acc

  initial begin
    nrst      = 1'b0;
    sar_code  = 14'h0000;
    short_res = 1'b0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    foreach (ks[j]) begin
      acc(ks[j], j[0], j[0] ^ j[1]);
      check(25'(acc_count), 25'(ks[j]));
      check(25'(word_bits), 25'(nb(ks[j], j[0] ^ j[1])));
      check(25'(sdo_oe), 25'h1);
      acsr_host_inst.rd(nb(ks[j], j[0] ^ j[1]) + int'(j[0]), w);
      check(w, 25'(sum) & ((25'h1 << nb(ks[j], j[0] ^ j[1])) - 1));
      check(25'(sdo_oe), 25'h0);
    end
    acc(2, 1'b0, 1'b0);
    acsr_host_inst.rd(1, w);
    acc(1, 1'b0, 1'b0);
    check(25'(acc_count), 25'h1);
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : acsr_top_tb_top
